// *** core/rwg_guard.sv ***
// Register write guard placed in front of one peripheral's registers.
// Assumes one request at a time on the upstream port and a protected
// module that answers every forwarded request with one ack pulse.
`timescale 1ns/100ps
// Overview of operation
// [RULE1] Lock only a module-specific register set
// [RULE2] Optionally reject non-supervisor accesses
// [RULE3] Soft lock blocks writes to its register
// [RULE4] Software write or reset releases soft lock
// [RULE5] Hard lock blocks all protected writes
// [RULE6] Only reset clears the hard lock
// [RULE7] One set-soft-lock bit per protectable register
// [RULE8] Hard lock bit in global config engages
// [RULE9] Software keeps registers locked most time
// [RULE10] Software reads back guard configuration
// [RULE11] Blocked access errors, target unchanged
module rwg_guard #(
  parameter int NUM_PROT = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Upstream bus from masters
  input wire logic up_valid,
  output logic up_ready,
  input wire rwg_pkg::rwg_req_s up_req,
  output logic up_rsp_valid,
  output rwg_pkg::rwg_rsp_s up_rsp,
  // Downstream to the protected module
  output logic dn_valid,
  output rwg_pkg::rwg_req_s dn_req,
  input wire logic dn_ack,
  input wire rwg_pkg::rwg_rsp_s dn_rsp,
  // Guard state for observation
  output logic hard_lock_bit,
  output logic [NUM_PROT-1:0] soft_lock
);
  import rwg_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (NUM_PROT < 1 || NUM_PROT > RWG_MAX_PROT)
  begin : g_bad_num_prot
    $error("NUM_PROT must be within 1..32");
  end

  // Every soft lock needs a word of its own in the guard's space
  if (NUM_PROT * 4 > int'(RWG_SOFT_LOCK_SPAN))
  begin : g_bad_span
    $error("Soft lock space too small for NUM_PROT");
  end

  // Decode relies on both guard locations sitting behind the select bit
  if (RWG_GCR_OFS[RWG_GUARD_SEL_BIT] != 1'b1
    || RWG_SOFT_LOCK_BASE[RWG_GUARD_SEL_BIT] != 1'b1)
  begin : g_bad_map
    $error("Guard locations must lie in the guard's space");
  end

  // Global config fields must fit the data word
  if (RWG_GCR_SUP_ONLY_BIT >= RWG_DATA_W
    || RWG_GCR_HARD_LOCK_BIT >= RWG_DATA_W)
  begin : g_bad_fields
    $error("Global config fields outside the data word");
  end

  rwg_state_e state;
  rwg_state_e next_state;
  logic sup_only;
  logic is_guard;
  logic is_gcr;
  logic is_soft;
  logic [4:0] idx;
  logic blocked;
  logic take;
  logic guard_wr;
  logic [RWG_DATA_W-1:0] guard_rdata;
  logic fwd;
  logic [NUM_PROT-1:0] soft_wr;
  rwg_rsp_s next_rsp;
  // Soft lock index bits; the decoder gates wider values off
  localparam int IDX_W = (NUM_PROT > 1) ? $clog2(NUM_PROT) : 1;

  // ****************************************
  // Decode
  // ****************************************
  rwg_check #(
    .NUM_PROT(NUM_PROT)
  ) u_check (
    .req(up_req),
    .soft_lock(soft_lock),
    .hard_lock(hard_lock_bit),
    .sup_only(sup_only),
    .is_guard(is_guard),
    .is_gcr(is_gcr),
    .is_soft(is_soft),
    .idx(idx),
    .blocked(blocked)
  );

  assign up_ready = (state == RWG_IDLE);
  assign take = up_valid && up_ready;
  assign guard_wr = take && !blocked && is_guard && up_req.write;
  assign fwd = take && !blocked && !is_guard; // RULE1

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      RWG_IDLE:
        if (take)
          next_state = (blocked || is_guard) ? RWG_RESP : RWG_FWD;
      RWG_FWD:
        // A stray ack outside this state is ignored
        if (dn_ack)
          next_state = RWG_RESP;
      RWG_RESP:
        next_state = RWG_IDLE;
      default:
        next_state = RWG_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      state <= RWG_IDLE;
    else
      state <= next_state;
  end

  // ****************************************
  // Guard's own configuration
  // ****************************************
  // Hard lock is set-only; no write path clears it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      hard_lock_bit <= RWG_HARD_LOCK_RST; // RULE6
    else if (guard_wr && is_gcr && up_req.wdata[RWG_GCR_HARD_LOCK_BIT])
      hard_lock_bit <= 1'b1; // RULE8
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      sup_only <= RWG_SUP_ONLY_RST;
    else if (guard_wr && is_gcr)
      sup_only <= up_req.wdata[RWG_GCR_SUP_ONLY_BIT]; // RULE2
  end

  // ****************************************
  // Soft locks
  // ****************************************
  // A supervisor write of 0 releases a lock unless the hard lock froze the guard space
  for (genvar i = 0; i < NUM_PROT; i++)
  begin : g_soft
    assign soft_wr[i] = guard_wr && is_soft && (int'(idx) == i); // RULE7
    always_ff @(posedge clk_sys)
    begin
      if (!rst_b)
        soft_lock[i] <= RWG_SOFT_LOCK_RST; // RULE4
      else if (soft_wr[i])
        soft_lock[i] <= up_req.wdata[RWG_SOFT_LOCK_BIT]; // RULE7 RULE4
    end
  end

  // Guard writes answer with the value held before the write
  always_comb
  begin
    guard_rdata = '0;
    if (is_gcr)
    begin
      guard_rdata[RWG_GCR_HARD_LOCK_BIT] = hard_lock_bit;
      guard_rdata[RWG_GCR_SUP_ONLY_BIT] = sup_only;
    end
    else if (is_soft)
      guard_rdata[RWG_SOFT_LOCK_BIT] = soft_lock[idx[IDX_W-1:0]];
  end

  // ****************************************
  // Forwarding and answers
  // ****************************************
  // Blocked requests never reach the module, so its contents stay intact
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      dn_valid <= 1'b0;
    else
      dn_valid <= fwd; // RULE11
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      dn_req <= '0;
    else if (fwd)
      dn_req <= up_req;
  end

  // Blocked answers carry no data, so nothing leaks past a lock
  always_comb
  begin
    next_rsp = up_rsp;
    if (take && blocked)
      next_rsp = '{err: 1'b1, rdata: '0}; // RULE11
    else if (take && is_guard)
      next_rsp = '{err: 1'b0, rdata: guard_rdata};
    else if (state == RWG_FWD && dn_ack)
      next_rsp = dn_rsp;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      up_rsp <= '0;
    else
      up_rsp <= next_rsp;
  end

  assign up_rsp_valid = (state == RWG_RESP);

endmodule : rwg_guard

// *** core/rwg_pkg.sv ***
// Package for the register write guard: bus carriers, address map, fields.
// Assumes one peripheral bus clock and 32-bit word-aligned accesses.
package rwg_pkg;

  // ****************************************
  // Bus widths and address map
  // ****************************************
  localparam int RWG_ADDR_W = 12;
  localparam int RWG_DATA_W = 32;
  // Address bit that selects the guard's own space
  localparam int RWG_GUARD_SEL_BIT = 11;
  localparam logic [RWG_ADDR_W-1:0] RWG_GCR_OFS = 12'h800;
  localparam logic [RWG_ADDR_W-1:0] RWG_SOFT_LOCK_BASE = 12'h900;
  localparam logic [RWG_ADDR_W-1:0] RWG_SOFT_LOCK_SPAN = 12'h080;
  localparam int RWG_MAX_PROT = 32;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int RWG_GCR_HARD_LOCK_BIT = 0;
  localparam int RWG_GCR_SUP_ONLY_BIT = 1;
  localparam int RWG_SOFT_LOCK_BIT = 0;
  localparam logic RWG_HARD_LOCK_RST = 1'b0;
  localparam logic RWG_SUP_ONLY_RST = 1'b0;
  localparam logic RWG_SOFT_LOCK_RST = 1'b0;

  typedef struct packed {
    logic write;
    logic supervisor;
    logic [RWG_ADDR_W-1:0] addr;
    logic [RWG_DATA_W-1:0] wdata;
  } rwg_req_s;

  typedef struct packed {
    logic err;
    logic [RWG_DATA_W-1:0] rdata;
  } rwg_rsp_s;

  typedef enum logic [1:0] {
    RWG_IDLE = 2'b00,
    RWG_FWD = 2'b01,
    RWG_RESP = 2'b11
  } rwg_state_e;

endpackage : rwg_pkg

// *** core/rwg_check.sv ***
// Access classifier of the register write guard: decodes one request.
// Assumes the caller holds the request stable while it samples the result.
`timescale 1ns/100ps
module rwg_check #(
  parameter int NUM_PROT = 8
) (
  // Request under test
  input wire rwg_pkg::rwg_req_s req,
  // Guard state
  input wire logic [NUM_PROT-1:0] soft_lock,
  input wire logic hard_lock,
  input wire logic sup_only,
  // Decision
  output logic is_guard,
  output logic is_gcr,
  output logic is_soft,
  output logic [4:0] idx,
  output logic blocked
);
  import rwg_pkg::*;

  // Soft lock index bits; wider index values are gated off by the decode
  localparam int IDX_W = (NUM_PROT > 1) ? $clog2(NUM_PROT) : 1;

  logic [RWG_ADDR_W-1:0] soft_ofs;
  logic prot_hit;
  logic soft_hit;

  always_comb
  begin
    is_guard = req.addr[RWG_GUARD_SEL_BIT];
    is_gcr = is_guard && (req.addr == RWG_GCR_OFS);
    soft_ofs = req.addr - RWG_SOFT_LOCK_BASE;
    idx = is_guard ? soft_ofs[6:2] : req.addr[6:2];
    soft_hit = is_guard && (req.addr >= RWG_SOFT_LOCK_BASE)
      && (soft_ofs < RWG_SOFT_LOCK_SPAN) && (req.addr[1:0] == 2'h0)
      && (int'(idx) < NUM_PROT);
    is_soft = soft_hit;
    // Only the first NUM_PROT words of the module can be locked
    prot_hit = !is_guard && (req.addr[RWG_GUARD_SEL_BIT-1:7] == '0)
      && (int'(idx) < NUM_PROT); // RULE1
    blocked = 1'b0;
    if (sup_only && !req.supervisor)
      blocked = 1'b1; // RULE2
    else if (is_guard && !is_gcr && !soft_hit)
      blocked = 1'b1;
    else if (is_guard && req.write && !req.supervisor)
      blocked = 1'b1;
    else if (is_guard && req.write && hard_lock)
      blocked = 1'b1; // RULE6
    else if (prot_hit && req.write && hard_lock)
      blocked = 1'b1; // RULE5
    else if (prot_hit && req.write && soft_lock[idx[IDX_W-1:0]])
      blocked = 1'b1; // RULE3
  end

endmodule : rwg_check

// *** tb/rwg_guard_asserts.sv ***
// Port checker for the register write guard.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module rwg_guard_asserts #(
  parameter int NUM_PROT = 8
) (
  // Clock, reset, upstream
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic up_valid,
  input wire logic up_ready,
  input wire rwg_pkg::rwg_req_s up_req,
  input wire logic up_rsp_valid,
  input wire rwg_pkg::rwg_rsp_s up_rsp,
  // Downstream and lock state
  input wire logic dn_valid,
  input wire logic hard_lock_bit,
  input wire logic [NUM_PROT-1:0] soft_lock
);
  import rwg_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic sup;
  logic [5:0] last;
  wire tk = up_valid && up_ready;
  wire [4:0] ix = up_req.addr[6:2];
  wire pw = tk && up_req.write && up_req.addr[11:7] == 5'h00
    && ix < NUM_PROT && (hard_lock_bit || soft_lock[ix]);
  wire gw = tk && up_req.write && up_req.supervisor && !hard_lock_bit;
  // Supervisor-only field is not on any port
  always_ff @(posedge clk_sys)
    if (!rst_b)
      sup <= 1'b0;
    else if (gw && up_req.addr == 12'h800)
      sup <= up_req.wdata[1];
  always_ff @(posedge clk_sys)
    last <= {up_req.wdata[0], ix};
  a_hard_sticky: assert property (hard_lock_bit |=> hard_lock_bit)
    else $error("hard lock fell");
  a_hard_set: assert property (
    gw && up_req.addr == 12'h800 && up_req.wdata[0] |=> hard_lock_bit)
    else $error("hard lock not set");
  a_soft_block: assert property (
    pw && !hard_lock_bit |=> up_rsp_valid && up_rsp.err && !dn_valid)
    else $error("soft locked write passed");
  a_hard_block: assert property (
    pw && hard_lock_bit |=> up_rsp.err throughout !dn_valid [*2])
    else $error("hard locked write passed");
  a_mode_block: assert property (
    tk && sup && !up_req.supervisor |=> up_rsp.err && !dn_valid)
    else $error("user access passed");
  a_fwd_ok: assert property (
    tk && up_req.supervisor && !up_req.addr[11] && !pw |=> dn_valid)
    else $error("open access not forwarded");
  a_soft_set: assert property (
    gw && up_req.addr[11:7] == 5'h12 && ix < NUM_PROT
    |=> soft_lock[last[4:0]] == last[5])
    else $error("soft lock not written");
  a_guard_local: assert property (tk && up_req.addr[11] |=> !dn_valid)
    else $error("guard access forwarded");
endmodule : rwg_guard_asserts

// *** tb/rwg_mod_model.sv ***
// Model of the module behind the guard: word store, one ack per request.
// Assumes one request at a time; address bit 6 makes it answer slowly.
`timescale 1ns/100ps
module rwg_mod_model (
  // Clock
  input wire logic clk_sys,
  // Requests and answers
  input wire logic dn_valid,
  input wire rwg_pkg::rwg_req_s dn_req,
  output logic dn_ack,
  output rwg_pkg::rwg_rsp_s dn_rsp
);
  import rwg_pkg::*;
  logic [31:0] mem [0:31];
  logic [1:0] cnt;
  logic busy = 1'b0;
  initial dn_ack = 1'b0;
  initial dn_rsp = '0;
  always @(posedge clk_sys)
  begin
    dn_ack <= 1'b0;
    // Stale answer flips so it is never read by luck
    dn_rsp <= ~dn_rsp;
    if (dn_valid)
    begin
      busy <= 1'b1;
      cnt <= {2{dn_req.addr[6]}};
    end
    else if (busy && cnt != 2'h0)
      cnt <= cnt - 2'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      dn_ack <= 1'b1;
      dn_rsp <= {1'b0, dn_req.write ? 32'h0 : mem[dn_req.addr[6:2]]};
      if (dn_req.write)
        mem[dn_req.addr[6:2]] <= dn_req.wdata;
    end
  end
endmodule : rwg_mod_model

// *** tb/rwg_guard_test.sv ***
// Testbench for the register write guard with a module model.
// Assumes the package, guard, model and checker are compiled first.
`timescale 1ns/100ps
module rwg_guard_test;
  import rwg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic up_valid = 1'b0;
  rwg_req_s up_req = '0;
  logic up_ready, up_rsp_valid, dn_valid, dn_ack, hard_lock_bit;
  rwg_rsp_s up_rsp, dn_rsp;
  rwg_req_s dn_req;
  logic [7:0] soft_lock;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 clk_sys = ~clk_sys;
  rwg_guard #(
    .NUM_PROT(8)
  ) dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .up_valid(up_valid),
    .up_ready(up_ready),
    .up_req(up_req),
    .up_rsp_valid(up_rsp_valid),
    .up_rsp(up_rsp),
    .dn_valid(dn_valid),
    .dn_req(dn_req),
    .dn_ack(dn_ack),
    .dn_rsp(dn_rsp),
    .hard_lock_bit(hard_lock_bit),
    .soft_lock(soft_lock)
  );
  rwg_mod_model mdl (
    .clk_sys(clk_sys),
    .dn_valid(dn_valid),
    .dn_req(dn_req),
    .dn_ack(dn_ack),
    .dn_rsp(dn_rsp)
  );
  task end_sim;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Timeout ceiling well above the hundred or so cycles needed
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task chk(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // ws: {write, supervisor}; e: {err, rdata}
  task op(input logic [1:0] ws, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e);
    int n;
    @(negedge clk_sys);
    up_valid = 1'b1;
    up_req = '{ws[1], ws[0], a, d};
    @(posedge clk_sys);
    @(negedge clk_sys);
    up_valid = 1'b0;
    for (n = 0; n < 20 && up_rsp_valid !== 1'b1; n++)
      @(negedge clk_sys);
    chk({32'h0, up_rsp_valid}, 33'h1);
    chk({up_rsp.err, up_rsp.rdata}, e);
  endtask : op
  // Unlocked words pass through to the module
  task scn_open;
    op(2'h3, 12'h040, 32'h1234abcd, 33'h0);
    op(2'h1, 12'h040, 32'h0, 33'h1234abcd);
    op(2'h3, 12'h000, 32'h5a5a0001, 33'h0);
  endtask : scn_open
  // Guard writes answer with the lock value held before the write
  task scn_soft;
    op(2'h3, 12'h900, 32'h1, 33'h0);
    op(2'h1, 12'h900, 32'h0, 33'h1);
    op(2'h3, 12'h000, 32'hdead, 33'h100000000);
    op(2'h1, 12'h000, 32'h0, 33'h5a5a0001);
    op(2'h3, 12'h900, 32'h0, 33'h1);
    op(2'h3, 12'h000, 32'h22, 33'h0);
    op(2'h1, 12'h000, 32'h0, 33'h22);
  endtask : scn_soft
  task scn_mode;
    op(2'h3, 12'h800, 32'h2, 33'h0);
    op(2'h0, 12'h040, 32'h0, 33'h100000000);
    op(2'h1, 12'h040, 32'h0, 33'h1234abcd);
    op(2'h3, 12'h800, 32'h0, 33'h2);
    op(2'h0, 12'h040, 32'h0, 33'h1234abcd);
  endtask : scn_mode
  task scn_hard;
    op(2'h3, 12'h904, 32'h1, 33'h0);
    op(2'h3, 12'h800, 32'h1, 33'h0);
    op(2'h3, 12'h01c, 32'h5, 33'h100000000);
    op(2'h3, 12'h800, 32'h0, 33'h100000000);
    op(2'h1, 12'h800, 32'h0, 33'h1);
    chk({24'h0, hard_lock_bit, soft_lock}, 33'h102);
  endtask : scn_hard
  task scn_reset;
    @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    chk({24'h0, hard_lock_bit, soft_lock}, 33'h0);
    op(2'h1, 12'h800, 32'h0, 33'h0);
    op(2'h3, 12'h004, 32'h9, 33'h0);
    op(2'h1, 12'h004, 32'h0, 33'h9);
  endtask : scn_reset
  initial
  begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    scn_open();
    scn_soft();
    scn_mode();
    scn_hard();
    scn_reset();
    end_sim();
  end
endmodule : rwg_guard_test
bind rwg_guard rwg_guard_asserts #(
  .NUM_PROT(NUM_PROT)
) u_chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .up_valid(up_valid),
  .up_ready(up_ready),
  .up_req(up_req),
  .up_rsp_valid(up_rsp_valid),
  .up_rsp(up_rsp),
  .dn_valid(dn_valid),
  .hard_lock_bit(hard_lock_bit),
  .soft_lock(soft_lock)
);
